// ### design/e1rxe_pkg.sv
// Purpose: constants and carriers for the E1 rx error counter bank
// Assumes: one 25 MHz clock; framer events arrive on that clock
// Notes: register port is read only; masks and select are pins
// Overview of operation
// RL1: 16-bit violation counter, low byte 0x17
// RL2: Select low: count only non-substitution bipolar violations
// RL3: Select high: also count excess zero runs
// RL4: CRC counter bytes at 0x18 and 0x19
// RL5: Bits set only unmasked; read clears returned
// RL6: Word zero bit 7: frame sync change
// RL7: Word zero bit 6: multiframe sync change
// RL8: Word zero bit 5: CRC sync change
// RL9: Word zero bit 4: all-ones alarm change
// RL10: Word zero bit 3: analog or digital loss
// RL11: Word zero bit 2: two errored alignment words
// RL12: Word zero bit 1: multiframe alignment lost
// RL13: Word zero bit 0: controlled frame slip
// RL14: Word one bit 7: alignment bit error in sync
// RL15: Word one bit 6: local CRC check fails
// RL16: Word one bit 5: received E-bit error
// RL17: Word one bit 4: timeslot 16 all ones
// RL18: Word one bit 3: line code violation seen
// RL19: Word one bit 2: PRBS checker error
// RL20: Word one bit 1: 512 alternating bits
// RL21: Word one bit 0: non-alignment bit 3 high
// RL22: Counter wrap to zero gives separate flag
// RL23: Event during clearing read stays set
package e1rxe_pkg;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_VIOL_HI = 5'h16;
    localparam logic [ADDR_W-1:0] OFS_VIOL_LO = 5'h17;
    localparam logic [ADDR_W-1:0] OFS_CRC_HI = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_CRC_LO = 5'h19;
    localparam logic [ADDR_W-1:0] OFS_IRQ0 = 5'h1B;
    localparam logic [ADDR_W-1:0] OFS_IRQ1 = 5'h1C;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;
    localparam int AUX_CNT_W = 10;
    localparam logic [AUX_CNT_W-1:0] AUX_RUN = 10'h200;
    localparam logic [AUX_CNT_W-1:0] AUX_ONE = 10'h001;
    localparam logic [AUX_CNT_W-1:0] AUX_NONE = 10'h000;
    localparam int B0_FSYNC = 7;
    localparam int B0_MFSYNC = 6;
    localparam int B0_CRCSYNC = 5;
    localparam int B0_AIS = 4;
    localparam int B0_LOS = 3;
    localparam int B0_DFAS = 2;
    localparam int B0_MFLOSS = 1;
    localparam int B0_SLIP = 0;
    localparam int B1_FASERR = 7;
    localparam int B1_CRCERR = 6;
    localparam int B1_EBIT = 5;
    localparam int B1_TS16 = 4;
    localparam int B1_BPV = 3;
    localparam int B1_PRBS = 2;
    localparam int B1_AUX = 1;
    localparam int B1_RAI = 0;

    typedef struct packed {
        logic excess_zero_select;
        logic [7:0] irq0_mask;
        logic [7:0] irq1_mask;
    } e1rxe_cfg_t;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic [ADDR_W-1:0] addr;
    } e1rxe_bus_t;

    typedef struct packed {
        logic frame_sync;
        logic mfrm_sync;
        logic crc_sync;
        logic all_ones;
        logic los_analog;
        logic los_digital;
        logic fas_strobe;
        logic fas_errored;
        logic slip;
        logic crc_fail;
        logic ebit_error;
        logic ts16_ones;
        logic bipolar_viol;
        logic excess_zeros;
        logic prbs_error;
        logic bit_strobe;
        logic bit_value;
        logic nfas_strobe;
        logic nfas_bit3;
    } e1rxe_evt_t;
endpackage

// ### design/e1rxe_top.sv
// Purpose: E1 rx error counters and read-clear irq status words
// Assumes: port pins asynchronous; events synchronous to CLK
// Notes: writes are not supported; unmapped reads return zero
`timescale 1ns/10ps
`default_nettype none
module e1rxe_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic [e1rxe_pkg::ADDR_W-1:0] ADDR,
    input wire e1rxe_pkg::e1rxe_cfg_t CFG,
    input wire e1rxe_pkg::e1rxe_evt_t EVT,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic VIOL_WRAP,
    output logic CRC_WRAP
);
    import e1rxe_pkg::*;

    // Counter step with wrap flag in the top bit
    function automatic logic [16:0] cnt_step(input logic [15:0] c);
        logic [16:0] r;
        r = {1'b0, c + CNT_ONE};
        if (c == CNT_FULL) begin
            r[16] = 1'b1;
        end
        return r;
    endfunction

    e1rxe_bus_t bus_m_q;
    e1rxe_bus_t bus_s_q;
    e1rxe_cfg_t cfg_m_q;
    e1rxe_cfg_t cfg_s_q;
    logic rd_act;
    logic rd_act_q;
    logic rd_start;
    logic rd_end;
    logic [ADDR_W-1:0] rd_addr_q;
    logic [15:0] viol_cnt_q;
    logic [15:0] crc_cnt_q;
    logic viol_hit;
    logic [16:0] viol_nxt;
    logic [16:0] crc_nxt;
    logic [7:0] irq0_q;
    logic [7:0] irq1_q;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic fsync_q;
    logic mfsync_q;
    logic csync_q;
    logic ais_q;
    logic fas_prev_q;
    logic last_bit_q;
    logic [AUX_CNT_W-1:0] aux_cnt_q;
    logic aux_alt;
    logic aux_hit;

    // Port pins and straps come from outside the clock domain
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bus_m_q <= '{cs_n: 1'b1, rd_n: 1'b1, addr: '0};
            bus_s_q <= '{cs_n: 1'b1, rd_n: 1'b1, addr: '0};
        end else begin
            bus_m_q <= '{cs_n: CS_N, rd_n: RD_N, addr: ADDR};
            bus_s_q <= bus_m_q;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_m_q <= '0;
            cfg_s_q <= '0;
        end else begin
            cfg_m_q <= CFG;
            cfg_s_q <= cfg_m_q;
        end
    end

    // Read strobe edges
    assign rd_act = ~bus_s_q.cs_n & ~bus_s_q.rd_n;
    assign rd_start = rd_act & ~rd_act_q;
    assign rd_end = ~rd_act & rd_act_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_act_q <= 1'b0;
            rd_addr_q <= '0;
        end else begin
            rd_act_q <= rd_act;
            if (rd_start) begin
                rd_addr_q <= bus_s_q.addr;
            end
        end
    end

    // Data is captured at strobe start and held for the whole read
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            DATA_OUT <= BYTE_ZERO;
            DATA_OE <= 1'b0;
        end else begin
            DATA_OE <= rd_act;
            if (rd_start) begin
                case (bus_s_q.addr)
                    OFS_VIOL_HI: DATA_OUT <= viol_cnt_q[15:8];
                    OFS_VIOL_LO: DATA_OUT <= viol_cnt_q[7:0]; // RL1
                    OFS_CRC_HI: DATA_OUT <= crc_cnt_q[15:8]; // RL4
                    OFS_CRC_LO: DATA_OUT <= crc_cnt_q[7:0]; // RL4
                    OFS_IRQ0: DATA_OUT <= irq0_q;
                    OFS_IRQ1: DATA_OUT <= irq1_q;
                    default: DATA_OUT <= BYTE_ZERO;
                endcase
            end
        end
    end

    // Line code violation qualification
    assign viol_hit = EVT.bipolar_viol // RL2
        | (cfg_s_q.excess_zero_select & EVT.excess_zeros); // RL3
    assign viol_nxt = cnt_step(viol_cnt_q);
    assign crc_nxt = cnt_step(crc_cnt_q);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            viol_cnt_q <= CNT_ZERO;
            VIOL_WRAP <= 1'b0;
        end else begin
            VIOL_WRAP <= viol_hit & viol_nxt[16]; // RL22
            if (viol_hit) begin
                viol_cnt_q <= viol_nxt[15:0]; // RL1
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            crc_cnt_q <= CNT_ZERO;
            CRC_WRAP <= 1'b0;
        end else begin
            CRC_WRAP <= EVT.crc_fail & crc_nxt[16]; // RL22
            if (EVT.crc_fail) begin
                crc_cnt_q <= crc_nxt[15:0]; // RL4
            end
        end
    end

    // Previous levels for change detection; zero after reset,
    // but a level already high at release reports nothing: the synced masks are still zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            fsync_q <= 1'b0;
            mfsync_q <= 1'b0;
            csync_q <= 1'b0;
            ais_q <= 1'b0;
        end else begin
            fsync_q <= EVT.frame_sync;
            mfsync_q <= EVT.mfrm_sync;
            csync_q <= EVT.crc_sync;
            ais_q <= EVT.all_ones;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            fas_prev_q <= 1'b0;
        end else if (EVT.fas_strobe) begin
            fas_prev_q <= EVT.fas_errored;
        end
    end

    // Alternating pattern run length, saturates at the target
    assign aux_alt = (aux_cnt_q != AUX_NONE)
        & (EVT.bit_value != last_bit_q);
    assign aux_hit = EVT.bit_strobe & aux_alt
        & (aux_cnt_q == AUX_RUN - AUX_ONE);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aux_cnt_q <= AUX_NONE;
            last_bit_q <= 1'b0;
        end else if (EVT.bit_strobe) begin
            last_bit_q <= EVT.bit_value;
            if (!aux_alt) begin
                aux_cnt_q <= AUX_ONE;
            end else if (aux_cnt_q != AUX_RUN) begin
                aux_cnt_q <= aux_cnt_q + AUX_ONE; // RL20
            end
        end
    end

    always_comb begin
        set0 = BYTE_ZERO;
        set0[B0_FSYNC] = EVT.frame_sync ^ fsync_q; // RL6
        set0[B0_MFSYNC] = EVT.mfrm_sync ^ mfsync_q; // RL7
        set0[B0_CRCSYNC] = EVT.crc_sync ^ csync_q; // RL8
        set0[B0_AIS] = EVT.all_ones ^ ais_q; // RL9
        set0[B0_LOS] = EVT.los_analog | EVT.los_digital; // RL10
        set0[B0_DFAS] = EVT.fas_strobe & EVT.fas_errored
            & fas_prev_q; // RL11
        set0[B0_MFLOSS] = mfsync_q & ~EVT.mfrm_sync; // RL12
        set0[B0_SLIP] = EVT.slip; // RL13
        set0 = set0 & cfg_s_q.irq0_mask; // RL5
    end

    always_comb begin
        set1 = BYTE_ZERO;
        set1[B1_FASERR] = EVT.fas_strobe & EVT.fas_errored
            & EVT.frame_sync; // RL14
        set1[B1_CRCERR] = EVT.crc_fail; // RL15
        set1[B1_EBIT] = EVT.ebit_error; // RL16
        set1[B1_TS16] = EVT.ts16_ones; // RL17
        set1[B1_BPV] = EVT.bipolar_viol; // RL18
        set1[B1_PRBS] = EVT.prbs_error; // RL19
        set1[B1_AUX] = aux_hit; // RL20
        set1[B1_RAI] = EVT.nfas_strobe & EVT.nfas_bit3; // RL21
        set1 = set1 & cfg_s_q.irq1_mask; // RL5
    end

    // Only the bits the host saw are cleared, at strobe end
    always_comb begin
        clr0 = BYTE_ZERO;
        clr1 = BYTE_ZERO;
        if (rd_end && rd_addr_q == OFS_IRQ0) begin
            clr0 = DATA_OUT; // RL5
        end
        if (rd_end && rd_addr_q == OFS_IRQ1) begin
            clr1 = DATA_OUT; // RL5
        end
    end

    // Set beats clear so a late event survives the read
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq0_q <= BYTE_ZERO;
        end else begin
            irq0_q <= (irq0_q & ~clr0) | set0; // RL23
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq1_q <= BYTE_ZERO;
        end else begin
            irq1_q <= (irq1_q & ~clr1) | set1; // RL23
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    property p_viol_step;
        viol_hit |=> viol_cnt_q == $past(viol_cnt_q) + CNT_ONE;
    endproperty
    a_viol_step: assert property (p_viol_step) // RL1
        else $error("violation counter did not step");

    property p_zsel_off;
        !EVT.bipolar_viol && !cfg_s_q.excess_zero_select
            |=> $stable(viol_cnt_q);
    endproperty
    a_zsel_off: assert property (p_zsel_off) // RL2
        else $error("excess zeros counted while deselected");

    property p_zsel_on;
        cfg_s_q.excess_zero_select && EVT.excess_zeros
            |=> viol_cnt_q != $past(viol_cnt_q);
    endproperty
    a_zsel_on: assert property (p_zsel_on) // RL3
        else $error("excess zeros not counted");

    property p_crc_read;
        rd_start && bus_s_q.addr == OFS_CRC_HI
            |=> DATA_OUT == $past(crc_cnt_q[15:8]) && DATA_OE;
    endproperty
    a_crc_read: assert property (p_crc_read) // RL4
        else $error("CRC high byte read wrong");

    property p_mask0;
        ((irq0_q & ~$past(irq0_q)) & ~$past(cfg_s_q.irq0_mask))
            == BYTE_ZERO;
    endproperty
    a_mask0: assert property (p_mask0) // RL5
        else $error("masked word zero bit set");

    property p_fsync;
        $changed(EVT.frame_sync) && cfg_s_q.irq0_mask[B0_FSYNC]
            |=> irq0_q[B0_FSYNC];
    endproperty
    a_fsync: assert property (p_fsync) // RL6
        else $error("frame sync change missed");

    property p_dfas;
        EVT.fas_strobe && EVT.fas_errored && fas_prev_q
            && cfg_s_q.irq0_mask[B0_DFAS]
            |=> irq0_q[B0_DFAS];
    endproperty
    a_dfas: assert property (p_dfas) // RL11
        else $error("double alignment error missed");

    // A repeated bit must restart the run, or noise could alarm
    property p_aux_restart;
        EVT.bit_strobe && !aux_alt |=> aux_cnt_q == AUX_ONE;
    endproperty
    a_aux_restart: assert property (p_aux_restart) // RL20
        else $error("alternating run did not restart");

    property p_aux_set;
        aux_hit && cfg_s_q.irq1_mask[B1_AUX]
            |=> irq1_q[B1_AUX] && aux_cnt_q == AUX_RUN;
    endproperty
    a_aux_set: assert property (p_aux_set) // RL20
        else $error("alternating pattern flag missed");

    property p_wrap;
        viol_hit && viol_cnt_q == CNT_FULL
            |=> VIOL_WRAP && viol_cnt_q == CNT_ZERO;
    endproperty
    a_wrap: assert property (p_wrap) // RL22
        else $error("counter wrap not reported");

    property p_crc_step;
        EVT.crc_fail |=> crc_cnt_q == $past(crc_cnt_q) + CNT_ONE;
    endproperty
    a_crc_step: assert property (p_crc_step) // RL4
        else $error("CRC counter did not step");

    property p_los;
        (EVT.los_analog || EVT.los_digital) && cfg_s_q.irq0_mask[B0_LOS]
            |=> irq0_q[B0_LOS];
    endproperty
    a_los: assert property (p_los) // RL10
        else $error("signal loss not flagged");

    property p_mfloss;
        $fell(EVT.mfrm_sync) && cfg_s_q.irq0_mask[B0_MFLOSS]
            |=> irq0_q[B0_MFLOSS];
    endproperty
    a_mfloss: assert property (p_mfloss) // RL12
        else $error("multiframe loss not flagged");

    property p_slip;
        EVT.slip && cfg_s_q.irq0_mask[B0_SLIP] |=> irq0_q[B0_SLIP];
    endproperty
    a_slip: assert property (p_slip) // RL13
        else $error("frame slip not flagged");

    property p_fas_err;
        EVT.fas_strobe && EVT.fas_errored && EVT.frame_sync
            && cfg_s_q.irq1_mask[B1_FASERR] |=> irq1_q[B1_FASERR];
    endproperty
    a_fas_err: assert property (p_fas_err) // RL14
        else $error("alignment bit error not flagged");

    property p_rai;
        EVT.nfas_strobe && EVT.nfas_bit3 && cfg_s_q.irq1_mask[B1_RAI]
            |=> irq1_q[B1_RAI];
    endproperty
    a_rai: assert property (p_rai) // RL21
        else $error("remote alarm not flagged");

    property p_keep;
        rd_end && rd_addr_q == OFS_IRQ1 && set1[B1_CRCERR]
            |=> irq1_q[B1_CRCERR];
    endproperty
    a_keep: assert property (p_keep) // RL23
        else $error("event lost during clearing read");

    property p_clear;
        rd_end && rd_addr_q == OFS_IRQ0 && set0 == BYTE_ZERO
            |=> (irq0_q & $past(DATA_OUT)) == BYTE_ZERO;
    endproperty
    a_clear: assert property (p_clear) // RL5
        else $error("read did not clear returned bits");
endmodule
`default_nettype wire

// ### sim/e1rxe_framer_model.sv
// Purpose: receive framer stand-in that raises the event inputs
// Assumes: events are synchronous to CLK; pulses last one cycle
// Notes: the bench calls the tasks; levels persist between calls
`timescale 1ns/10ps
`default_nettype none
module e1rxe_framer_model (
    input wire logic CLK,
    output var e1rxe_pkg::e1rxe_evt_t EVT
);
    import e1rxe_pkg::*;
    e1rxe_evt_t lv = '0;
    logic last_bit = 1'b0;
    initial EVT = '0;

    task automatic step();
        @(posedge CLK);
        EVT <= lv;
    endtask

    task automatic emit(input e1rxe_evt_t p);
        @(posedge CLK);
        EVT <= lv | p;
        step();
    endtask

    // First bit repeats the last one, so a fresh run starts at one
    task automatic aux_run(input int n);
        e1rxe_evt_t p;
        p = '0;
        p.bit_strobe = 1'b1;
        p.bit_value = last_bit;
        for (int i = 0; i < n; i++) begin
            @(posedge CLK);
            EVT <= lv | p;
            last_bit = p.bit_value;
            p.bit_value = !p.bit_value;
        end
        step();
    endtask

    task automatic burst(input int n, input int kind);
        e1rxe_evt_t p;
        p = '0;
        p.bipolar_viol = (kind == 0);
        p.excess_zeros = (kind == 1);
        p.crc_fail = (kind == 2);
        repeat (n) begin
            @(posedge CLK);
            EVT <= lv | p;
        end
        step();
    endtask

    // One event for status bit b of word w
    task automatic cause(input int w, input int b, input bit dig);
        e1rxe_evt_t p;
        p = '0;
        case ((w == 0) ? 8 + b : b)
            15: begin
                lv.frame_sync = 1'b0;
                step();
                lv.frame_sync = 1'b1;
            end
            14, 9: lv.mfrm_sync = (b == 6);
            13: lv.crc_sync = !lv.crc_sync;
            12: lv.all_ones = !lv.all_ones;
            11: if (dig) p.los_digital = 1'b1; else p.los_analog = 1'b1;
            10: begin
                p.fas_strobe = 1'b1;
                p.fas_errored = 1'b1;
                emit(p);
            end
            8: p.slip = 1'b1;
            7: begin
                p.fas_strobe = 1'b1;
                emit(p);
                p.fas_errored = 1'b1;
            end
            6: p.crc_fail = 1'b1;
            5: p.ebit_error = 1'b1;
            4: p.ts16_ones = 1'b1;
            3: p.bipolar_viol = 1'b1;
            2: p.prbs_error = 1'b1;
            1: aux_run(512);
            default: begin
                p.nfas_strobe = 1'b1;
                p.nfas_bit3 = 1'b1;
            end
        endcase
        emit(p);
    endtask
endmodule
`default_nettype wire

// ### sim/test_e1_rx_error_counters_irq_status.sv
// Purpose: self-checking bench for the rx error counter bank
// Assumes: framer model drives events; masks driven as pins
// Notes: full violation counter wrap takes about 65k cycles
`timescale 1ns/10ps
`default_nettype none
module test_e1_rx_error_counters_irq_status;
    import e1rxe_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic CS_N = 1'b1;
    logic RD_N = 1'b1;
    logic [ADDR_W-1:0] ADDR = '0;
    e1rxe_cfg_t CFG = '{1'b0, 8'hFF, 8'hFF};
    e1rxe_evt_t EVT;
    logic [7:0] DATA_OUT;
    logic DATA_OE;
    logic VIOL_WRAP;
    logic CRC_WRAP;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int viol_wraps = 0;
    int crc_wraps = 0;
    logic [15:0] exp_viol = 16'h0000;
    logic [15:0] exp_crc = 16'h0000;
    logic [15:0] e;
    logic [7:0] m0, m1, d;
    logic sel;
    int nb, nz, nc;

    always #20 CLK = ~CLK;

    e1rxe_top i_e1rxe_top (.CLK(CLK), .RST(RST), .CS_N(CS_N), .RD_N(RD_N),
        .ADDR(ADDR), .CFG(CFG), .EVT(EVT), .DATA_OUT(DATA_OUT),
        .DATA_OE(DATA_OE), .VIOL_WRAP(VIOL_WRAP), .CRC_WRAP(CRC_WRAP));
    e1rxe_framer_model i_e1rxe_framer_model (.CLK(CLK), .EVT(EVT));

    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (VIOL_WRAP === 1'b1) viol_wraps++;
        if (CRC_WRAP === 1'b1) crc_wraps++;
        // Ceiling well above the wrap burst plus status passes
        if (cycles == 90000) begin
            failures++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Pins held until the answer, then 4 idle edges for the clear
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        int n;
        @(posedge CLK);
        CS_N <= 1'b0;
        RD_N <= 1'b0;
        ADDR <= a;
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
        end while (DATA_OE !== 1'b1 && n < 8);
        chk("read answer", {15'h0000, DATA_OE}, 16'h0001);
        v = DATA_OUT;
        @(posedge CLK);
        CS_N <= 1'b1;
        RD_N <= 1'b1;
        repeat (4) @(posedge CLK);
    endtask

    task automatic rd_cnt(input logic [4:0] hi, input logic [15:0] ex);
        logic [7:0] v;
        rd(hi, v);
        chk("count high", {8'h00, v}, {8'h00, ex[15:8]});
        rd(hi + 5'h01, v);
        chk("count low", {8'h00, v}, {8'h00, ex[7:0]});
    endtask

    // Word zero in the upper byte; mfrm loss and double FAS add extras
    function automatic logic [15:0] expect_bits(input int w, input int b);
        logic [15:0] x;
        x = 16'h0001 << ((w == 0) ? b + 8 : b);
        if (w == 0 && b == 1) x |= 16'h4000;
        if (w == 0 && b == 2) x |= 16'h0080;
        return x;
    endfunction

    initial begin
        void'($urandom(47229));
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        repeat (3) @(posedge CLK);
        for (int a = 'h16; a <= 'h1C; a++) begin
            rd(a[4:0], d);
            chk("reset value", {8'h00, d}, 16'h0000);
        end
        for (int p = 0; p < 5; p++) begin
            m0 = (p == 0) ? 8'hFF : (p == 1) ? 8'h00 : 8'($urandom);
            m1 = (p == 0) ? 8'hFF : (p == 1) ? 8'h00 : 8'($urandom);
            CFG.irq0_mask <= m0;
            CFG.irq1_mask <= m1;
            repeat (4) @(posedge CLK);
            for (int w = 0; w < 2; w++) begin
                for (int b = 7; b >= 0; b--) begin
                    i_e1rxe_framer_model.cause(w, b, p[0]);
                    if (w == 1 && b == 3) exp_viol++;
                    if (w == 1 && b == 6) exp_crc++;
                    e = expect_bits(w, b);
                    rd(OFS_IRQ0, d);
                    chk("word zero", {8'h00, d}, {8'h00, e[15:8] & m0});
                    rd(OFS_IRQ1, d);
                    chk("word one", {8'h00, d}, {8'h00, e[7:0] & m1});
                end
            end
            rd(OFS_IRQ0, d);
            chk("word zero cleared", {8'h00, d}, 16'h0000);
            rd(OFS_IRQ1, d);
            chk("word one cleared", {8'h00, d}, 16'h0000);
        end
        CFG.irq0_mask <= 8'hFF;
        CFG.irq1_mask <= 8'hFF;
        repeat (4) @(posedge CLK);
        // CRC errors keep arriving while word one is being cleared
        fork
            rd(OFS_IRQ1, d);
            i_e1rxe_framer_model.burst(12, 2);
        join
        chk("seen during burst", {8'h00, d}, 16'h0040);
        exp_crc += 16'h000C;
        rd(OFS_IRQ1, d);
        chk("kept on clear", {8'h00, d}, 16'h0040);
        rd_cnt(OFS_CRC_HI, exp_crc);
        rd_cnt(OFS_VIOL_HI, exp_viol);
        for (int k = 0; k < 4; k++) begin
            sel = (k < 2) ? k[0] : 1'($urandom);
            CFG.excess_zero_select <= sel;
            repeat (4) @(posedge CLK);
            nb = $urandom_range(20, 1);
            nz = $urandom_range(20, 1);
            nc = $urandom_range(20, 1);
            i_e1rxe_framer_model.burst(nb, 0);
            i_e1rxe_framer_model.burst(nz, 1);
            i_e1rxe_framer_model.burst(nc, 2);
            exp_viol += 16'(nb + (sel ? nz : 0));
            exp_crc += 16'(nc);
            rd_cnt(OFS_VIOL_HI, exp_viol);
            rd_cnt(OFS_CRC_HI, exp_crc);
        end
        CFG.excess_zero_select <= 1'b0;
        repeat (4) @(posedge CLK);
        i_e1rxe_framer_model.burst(32'h0001_0003 - int'(exp_viol), 0);
        exp_viol = 16'h0003;
        repeat (2) @(posedge CLK);
        chk("violation wraps", 16'(viol_wraps), 16'h0001);
        chk("crc wraps", 16'(crc_wraps), 16'h0000);
        rd_cnt(OFS_VIOL_HI, exp_viol);
        complete_run();
    end
endmodule
`default_nettype wire
